// file: design/tbt_memory_map.sv
// battery tag memory map: command decode, scratchpads, backing stores, registers
//
// Behaviour
// RULE_01: bytes move least significant bit first
// RULE_02: five pages of 32 byte addresses
// RULE_03: page one holds 24 bytes 00h-17h
// RULE_04: page two holds 8 bytes 20h-27h
// RULE_05: page three: 32 scratch bytes plus volatile store
// RULE_06: writes hit scratchpad; copy command moves data
// RULE_07: scratch and backing share one byte layout
// RULE_08: lock blocks copies into page one store
// RULE_09: page four holds temperature and status
// RULE_10: page five holds identity and cycle count
// RULE_11: each conversion fills both held result registers
// RULE_12: 60h unsigned, half degree steps
// RULE_13: 61h signed, one degree steps
// RULE_14: busy flag high during conversion, low after
// RULE_15: reads past region end return all ones
// RULE_16: page three at 40h, page four at 60h
`timescale 1ns/1ns
module tbt_memory_map #(
    parameter int          NV_COPY_CYCLES = tbt_pkg::NV_COPY_CYCLES_DEF,
    parameter logic [15:0] ID_CODE        = tbt_pkg::ID_CODE_DEF
) (
    input  wire logic                        clock,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        frame_start,
    input  wire logic                        bit_stb,
    input  wire logic                        dq_in,
    output logic                             dq_out,
    output logic                             dq_oe_n,
    output logic                             temp_start,
    input  wire logic                        temp_done,
    input  wire logic [tbt_pkg::BYTE_W-1:0]  temp_half_in,
    input  wire logic [tbt_pkg::BYTE_W-1:0]  temp_signed_in,
    output logic                             nv_busy
);
    import tbt_pkg::*;

    localparam int NVC_W = $clog2(NV_COPY_CYCLES + 1);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    tbt_state_type       state_ff;
    tbt_state_type       nxt_state;
    logic [7:0]          ptr_ff;
    logic                past_ff;
    logic                regs_mode_ff;
    logic                write_mode_ff;
    logic                lock_ff;
    logic                tb_ff;
    logic                temp_start_ff;
    logic                dq_oe_n_ff;
    logic                nv_busy_ff;
    logic [NVC_W-1:0]    nv_cnt_ff;
    logic [NVC_W-1:0]    nxt_nv_cnt;
    logic [7:0]          temp_half_ff;
    logic [7:0]          temp_signed_ff;
    logic [15:0]         cyc_ff;
    logic [7:0]          scratch_ff [SCR_BYTES];
    logic [7:0]          back_ff    [SCR_BYTES];
    logic [7:0]          status_byte;
    logic [7:0]          reg_q;
    logic [7:0]          rx_byte;
    logic                rx_done;

    // ------------------------------------------------------------------
    // byte shifter
    // ------------------------------------------------------------------
    wire        got       = rx_done;
    wire        in_read   = (state_ff == ST_READ);
    wire [7:0]  look_addr = (state_ff == ST_ADDR) ? rx_byte : ptr_ff + 8'h01;
    wire [7:0]  reg_end   = ptr_ff[7] ? ADDR_CYC_HI : ADDR_STAT_HI;
    wire [7:0]  region_end = regs_mode_ff ? reg_end : ADDR_SCR_END;
    wire        at_end    = past_ff || (ptr_ff == region_end);
    wire        look_past = in_read && at_end;
    wire [7:0]  scr_q     = scr_ok(look_addr) ? scratch_ff[look_addr[6:0]] : BYTE_ONES;
    wire [7:0]  look_byte = look_past ? BYTE_ONES :               // [RULE_15]
                            (regs_mode_ff ? reg_q : scr_q);
    wire        load      = got && ((state_ff == ST_ADDR && !write_mode_ff) || in_read);

    tbt_shift u_shift (
        .clock       (clock),
        .rst         (rst),
        .ce          (ce),
        .frame_start (frame_start),
        .bit_stb     (bit_stb),
        .bit_in      (dq_in),
        .load        (load),
        .load_byte   (look_byte),
        .rx_byte     (rx_byte),
        .rx_done     (rx_done),
        .tx_bit      (dq_out)
    );

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    wire cmd_go    = (state_ff == ST_CMD) && got;
    wire is_rd_scr = cmd_go && (rx_byte == CMD_RD_SCR);
    wire is_wr_scr = cmd_go && (rx_byte == CMD_WR_SCR);
    wire is_rd_reg = cmd_go && (rx_byte == CMD_RD_REGS);
    wire is_conv   = cmd_go && (rx_byte == CMD_CONVERT);
    wire is_lock   = cmd_go && (rx_byte == CMD_LOCK);
    wire is_unlock = cmd_go && (rx_byte == CMD_UNLOCK);
    wire is_inc    = cmd_go && (rx_byte == CMD_CYC_INC);
    wire is_clr    = cmd_go && (rx_byte == CMD_CYC_CLR);
    wire has_addr  = is_rd_scr || is_wr_scr || is_rd_reg;

    // copies to the nonvolatile pages are refused while one is still running
    logic [NUM_COPY_PAGES-1:0] cp_back;
    logic [NUM_COPY_PAGES-1:0] cp_scr;
    assign cp_back[PG_ONE]   = cmd_go && (rx_byte == CMD_CP_SP1) && !nv_busy_ff && !lock_ff; // [RULE_08]
    assign cp_back[PG_TWO]   = cmd_go && (rx_byte == CMD_CP_SP2) && !nv_busy_ff; // [RULE_06]
    assign cp_back[PG_THREE] = cmd_go && (rx_byte == CMD_CP_SP3); // [RULE_05]
    assign cp_scr[PG_ONE]    = cmd_go && (rx_byte == CMD_LD_SP1);
    assign cp_scr[PG_TWO]    = cmd_go && (rx_byte == CMD_LD_SP2);
    assign cp_scr[PG_THREE]  = cmd_go && (rx_byte == CMD_LD_SP3);
    wire nv_start = cp_back[PG_ONE] || cp_back[PG_TWO];

    // reserved scratch bytes and anything past the scratch space are never written
    wire wr_en = (state_ff == ST_WRITE) && got && !past_ff && scr_ok(ptr_ff); // [RULE_02] [RULE_04]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_CMD:   if (got) nxt_state = has_addr ? ST_ADDR : ST_HOLD;
            ST_ADDR:  if (got) nxt_state = write_mode_ff ? ST_WRITE : ST_READ;
            ST_WRITE: nxt_state = ST_WRITE;
            ST_READ:  nxt_state = ST_READ;
            ST_HOLD:  nxt_state = ST_HOLD;
            default:  nxt_state = ST_HOLD;
        endcase
        if (frame_start) nxt_state = ST_CMD;
    end

    // ------------------------------------------------------------------
    // page four and five read mux
    // ------------------------------------------------------------------
    always_comb begin
        status_byte = BYTE_ZERO;
        status_byte[STAT_BUSY_BIT] = tb_ff; // [RULE_14]
        status_byte[STAT_NVB_BIT]  = nv_busy_ff;
        status_byte[STAT_LOCK_BIT] = lock_ff;
    end

    always_comb begin
        case (look_addr) // [RULE_09] [RULE_10] [RULE_16]
            ADDR_TEMP_HALF:   reg_q = temp_half_ff;
            ADDR_TEMP_SIGNED: reg_q = temp_signed_ff;
            ADDR_STAT_LO:     reg_q = status_byte;
            ADDR_STAT_HI:     reg_q = BYTE_ZERO;
            ADDR_ID_LO:       reg_q = ID_CODE[7:0];
            ADDR_ID_HI:       reg_q = ID_CODE[15:8];
            ADDR_CYC_LO:      reg_q = cyc_ff[7:0];
            ADDR_CYC_HI:      reg_q = cyc_ff[15:8];
            default:          reg_q = BYTE_ONES;
        endcase
    end

    // ------------------------------------------------------------------
    // transaction state
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff      <= ST_HOLD;
            ptr_ff        <= BYTE_ZERO;
            past_ff       <= 1'b0;
            regs_mode_ff  <= 1'b0;
            write_mode_ff <= 1'b0;
            dq_oe_n_ff    <= 1'b1;
        end else if (ce) begin
            state_ff   <= nxt_state;
            dq_oe_n_ff <= (nxt_state != ST_READ);
            if (is_rd_scr || is_wr_scr || is_rd_reg) begin
                regs_mode_ff  <= is_rd_reg;
                write_mode_ff <= is_wr_scr;
                past_ff       <= 1'b0;
            end
            if (got && state_ff == ST_ADDR) begin
                ptr_ff <= rx_byte;
            end else if (got && (state_ff == ST_WRITE || in_read)) begin
                ptr_ff  <= ptr_ff + 8'h01;
                past_ff <= at_end; // [RULE_15]
            end
        end
    end

    // ------------------------------------------------------------------
    // scratchpad and backing store, one entry per byte address
    // ------------------------------------------------------------------
    for (genvar gi = 0; gi < SCR_BYTES; gi++) begin : g_entry
        localparam int PG = gi / PAGE_BYTES;
        wire hit = wr_en && (ptr_ff[6:0] == 7'(gi));
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                scratch_ff[gi] <= BYTE_ZERO;
                back_ff[gi]    <= BYTE_ZERO;
            end else if (ce) begin
                if (hit) begin
                    scratch_ff[gi] <= rx_byte; // [RULE_03] [RULE_04] [RULE_05]
                end else if (cp_scr[PG]) begin
                    scratch_ff[gi] <= back_ff[gi];
                end
                if (cp_back[PG]) begin
                    back_ff[gi] <= scratch_ff[gi]; // [RULE_06] [RULE_07]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // lock, nonvolatile busy, temperature, cycle counter
    // ------------------------------------------------------------------
    assign nxt_nv_cnt = nv_start ? NVC_W'(NV_COPY_CYCLES) :
                        (nv_cnt_ff != '0) ? nv_cnt_ff - NVC_W'(1) : nv_cnt_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lock_ff        <= 1'b0;
            nv_cnt_ff      <= '0;
            nv_busy_ff     <= 1'b0;
            tb_ff          <= 1'b0;
            temp_start_ff  <= 1'b0;
            temp_half_ff   <= BYTE_ZERO;
            temp_signed_ff <= BYTE_ZERO;
            cyc_ff         <= CYC_ZERO;
        end else if (ce) begin
            if (is_lock) lock_ff <= 1'b1; // [RULE_08]
            else if (is_unlock) lock_ff <= 1'b0;
            nv_cnt_ff     <= nxt_nv_cnt;
            nv_busy_ff    <= (nxt_nv_cnt != '0);
            temp_start_ff <= is_conv;
            // a new start beats a completion in the same cycle
            if (is_conv) tb_ff <= 1'b1; // [RULE_14]
            else if (temp_done) tb_ff <= 1'b0;
            if (temp_done) begin
                temp_half_ff   <= temp_half_in;   // [RULE_11] [RULE_12]
                temp_signed_ff <= temp_signed_in; // [RULE_11] [RULE_13]
            end
            if (is_clr) cyc_ff <= CYC_ZERO; // [RULE_10]
            else if (is_inc) cyc_ff <= cyc_ff + CYC_STEP;
        end
    end

    assign dq_oe_n    = dq_oe_n_ff;
    assign temp_start = temp_start_ff;
    assign nv_busy    = nv_busy_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_conv_start;
        ce && is_conv ##1 tb_ff && temp_start;
    endsequence
    sequence s_conv_end;
        ce && temp_done && !is_conv ##1 !tb_ff;
    endsequence

    chk_lsb_first: assert property (ce && load |=> dq_out == $past(look_byte[0])) // [RULE_01]
        else $error("first bit sent is not the lsb of the loaded byte");
    chk_write_bound: assert property (wr_en |-> ptr_ff < ADDR_TEMP_HALF) // [RULE_02]
        else $error("scratch write outside the first three pages");
    chk_page1_write: assert property (ce && wr_en && ptr_ff <= ADDR_P1_LAST // [RULE_03]
        |=> scratch_ff[$past(ptr_ff[6:0])] == $past(rx_byte))
        else $error("page one scratch byte not written");
    chk_page2_reserved: assert property (state_ff == ST_WRITE && got // [RULE_04]
        && ptr_ff > ADDR_P2_LAST && ptr_ff < ADDR_P3_FIRST |-> !wr_en)
        else $error("reserved page two byte written");
    chk_page3_copy: assert property (ce && cp_back[PG_THREE] // [RULE_05]
        |=> back_ff[ADDR_P3_FIRST[6:0]] == $past(scratch_ff[ADDR_P3_FIRST[6:0]]))
        else $error("page three copy did not reach the store");
    chk_write_no_back: assert property (ce && wr_en && !(|cp_back) // [RULE_06]
        |=> back_ff[$past(ptr_ff[6:0])] == $past(back_ff[ptr_ff[6:0]]))
        else $error("scratch write changed the backing store");
    chk_page1_layout: assert property (ce && cp_back[PG_ONE] // [RULE_07]
        |=> back_ff[ADDR_P1_LAST[6:0]] == $past(scratch_ff[ADDR_P1_LAST[6:0]]))
        else $error("page one copy moved a byte to another offset");
    chk_lock_blocks: assert property (lock_ff && cmd_go && rx_byte == CMD_CP_SP1 // [RULE_08]
        |-> !cp_back[PG_ONE])
        else $error("copy into locked page one accepted");
    chk_conv_start: assert property (ce && is_conv |-> s_conv_start) // [RULE_14]
        else $error("conversion start did not raise busy");
    chk_conv_end: assert property (ce && temp_done && !is_conv |-> s_conv_end) // [RULE_14]
        else $error("busy still high after completion");
    chk_result_load: assert property (ce && temp_done // [RULE_11]
        |=> temp_half_ff == $past(temp_half_in) && temp_signed_ff == $past(temp_signed_in))
        else $error("result registers not loaded");
    chk_result_hold: assert property (!(ce && temp_done) |=> $stable(temp_half_ff) // [RULE_11]
        && $stable(temp_signed_ff))
        else $error("result registers changed without a conversion");
    chk_cycle_inc: assert property (ce && is_inc |=> cyc_ff == $past(cyc_ff) + CYC_STEP) // [RULE_10]
        else $error("cycle counter did not step");
    chk_past_ones: assert property (ce && load && look_past |=> dq_out) // [RULE_15]
        else $error("read past region end not all ones");
    chk_temp_addr: assert property (ce && load && regs_mode_ff && !look_past // [RULE_16]
        && look_addr == ADDR_TEMP_HALF |=> dq_out == $past(temp_half_ff[0]))
        else $error("60h does not read the half degree result");

endmodule // tbt_memory_map

// file: include/tbt_pkg.sv
// constants, commands and types shared by the battery tag memory map
package tbt_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int BYTE_W         = 8;
    localparam int PAGE_BYTES     = 32;
    localparam int NUM_PAGES      = 5;
    localparam int SCR_BYTES      = 96;
    localparam int NUM_COPY_PAGES = 3;
    localparam int PG_ONE         = 0;
    localparam int PG_TWO         = 1;
    localparam int PG_THREE       = 2;

    // ------------------------------------------------------------------
    // addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_P1_LAST      = 8'h17;
    localparam logic [7:0] ADDR_P2_FIRST     = 8'h20;
    localparam logic [7:0] ADDR_P2_LAST      = 8'h27;
    localparam logic [7:0] ADDR_P3_FIRST     = 8'h40;
    localparam logic [7:0] ADDR_SCR_END      = 8'h5F;
    localparam logic [7:0] ADDR_TEMP_HALF    = 8'h60;
    localparam logic [7:0] ADDR_TEMP_SIGNED  = 8'h61;
    localparam logic [7:0] ADDR_STAT_LO      = 8'h62;
    localparam logic [7:0] ADDR_STAT_HI      = 8'h63;
    localparam logic [7:0] ADDR_ID_LO        = 8'h80;
    localparam logic [7:0] ADDR_ID_HI        = 8'h81;
    localparam logic [7:0] ADDR_CYC_LO       = 8'h82;
    localparam logic [7:0] ADDR_CYC_HI       = 8'h83;

    // ------------------------------------------------------------------
    // commands
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_RD_SCR   = 8'h11;
    localparam logic [7:0] CMD_WR_SCR   = 8'h17;
    localparam logic [7:0] CMD_CP_SP1   = 8'h22;
    localparam logic [7:0] CMD_CP_SP2   = 8'h25;
    localparam logic [7:0] CMD_CP_SP3   = 8'h28;
    localparam logic [7:0] CMD_LD_SP1   = 8'h71;
    localparam logic [7:0] CMD_LD_SP2   = 8'h77;
    localparam logic [7:0] CMD_LD_SP3   = 8'h7A;
    localparam logic [7:0] CMD_LOCK     = 8'h43;
    localparam logic [7:0] CMD_UNLOCK   = 8'h44;
    localparam logic [7:0] CMD_CONVERT  = 8'hD2;
    localparam logic [7:0] CMD_RD_REGS  = 8'hB2;
    localparam logic [7:0] CMD_CYC_INC  = 8'hB5;
    localparam logic [7:0] CMD_CYC_CLR  = 8'hB8;

    // ------------------------------------------------------------------
    // status byte, values, timing
    // ------------------------------------------------------------------
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_NVB_BIT  = 1;
    localparam int STAT_LOCK_BIT = 2;

    localparam logic [7:0]  BYTE_ONES  = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO  = 8'h00;
    localparam logic [15:0] CYC_ZERO   = 16'h0000;
    localparam logic [15:0] CYC_STEP   = 16'h0001;
    localparam logic [2:0]  BIT_LAST   = 3'h7;
    localparam logic [2:0]  BIT_STEP   = 3'h1;
    localparam logic [2:0]  BIT_FIRST  = 3'h0;
    // arbitrary neutral identity value
    localparam logic [15:0] ID_CODE_DEF = 16'h5A3C;

    localparam int CLK_MHZ           = 100;
    localparam int NV_COPY_MS        = 10;
    localparam int NV_COPY_CYCLES_DEF = NV_COPY_MS * 1000 * CLK_MHZ;

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_WRITE, ST_READ, ST_HOLD} tbt_state_type;

    // true where a scratchpad byte really exists
    function automatic logic scr_ok(input logic [7:0] a);
        return (a <= ADDR_P1_LAST) || ((a >= ADDR_P2_FIRST) && (a <= ADDR_P2_LAST)) ||
               ((a >= ADDR_P3_FIRST) && (a <= ADDR_SCR_END));
    endfunction

endpackage

// file: design/tbt_shift.sv
// byte shifter for the serial data pin, least significant bit first
`timescale 1ns/1ns
module tbt_shift (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              frame_start,
    input  wire logic              bit_stb,
    input  wire logic              bit_in,
    input  wire logic              load,
    input  wire logic [7:0]        load_byte,
    output logic      [7:0]        rx_byte,
    output logic                   rx_done,
    output logic                   tx_bit
);
    import tbt_pkg::*;

    logic [7:0] sr_ff;
    logic [2:0] cnt_ff;
    logic       done_ff;
    wire        last_bit = (cnt_ff == BIT_LAST);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sr_ff   <= BYTE_ZERO;
            cnt_ff  <= BIT_FIRST;
            done_ff <= 1'b0;
        end else if (ce) begin
            done_ff <= 1'b0;
            if (frame_start) begin
                cnt_ff <= BIT_FIRST;
            end else if (load) begin
                sr_ff <= load_byte;
            end else if (bit_stb) begin
                sr_ff   <= {bit_in, sr_ff[7:1]}; // [RULE_01]
                cnt_ff  <= cnt_ff + BIT_STEP;
                done_ff <= last_bit;
            end
        end
    end

    assign rx_byte = sr_ff;
    assign rx_done = done_ff;
    assign tx_bit  = sr_ff[0]; // [RULE_01]

endmodule // tbt_shift

// file: sim/tbt_master.sv
// single-wire bus master model: frames, bit slots, byte transfer
`timescale 1ns/1ns
module tbt_master (
    input  wire logic clock,
    input  wire logic line_lvl,
    output logic      frame_start,
    output logic      bit_stb,
    output logic      mst_bit
);
    initial begin
        frame_start = 1'b0;
        bit_stb     = 1'b0;
        mst_bit     = 1'b1;
    end

    task automatic frame();
        @(posedge clock);
        frame_start <= 1'b1;
        @(posedge clock);
        frame_start <= 1'b0;
    endtask

    // one slot every four cycles; between slots the line is left to its pull-up
    task automatic slot(input logic b, output logic smp);
        @(posedge clock);
        smp = line_lvl;
        bit_stb <= 1'b1;
        mst_bit <= b;
        @(posedge clock);
        bit_stb <= 1'b0;
        mst_bit <= 1'b1;
        repeat (2) @(posedge clock);
    endtask

    task automatic put(input logic [7:0] v);
        logic s;
        for (int i = 0; i < 8; i++) slot(v[i], s);
    endtask

    task automatic get(output logic [7:0] v);
        for (int i = 0; i < 8; i++) slot(1'b1, v[i]);
    endtask
endmodule // tbt_master

// file: sim/tb.sv
// self-checking bench for the battery tag memory map
`timescale 1ns/1ns
module tb;
    import tbt_pkg::*;
    logic       clock     = 1'b0;
    logic       rst       = 1'b1;
    logic       ce        = 1'b1;
    logic       temp_done = 1'b0;
    logic [7:0] t_half    = 8'h00;
    logic [7:0] t_sgn     = 8'h00;
    logic       frame_start, bit_stb, mst_bit, dq_out, dq_oe_n, temp_start, nv_busy;
    // open-drain wire: either party may pull low
    wire        line_lvl  = mst_bit & (dq_oe_n | dq_out);
    int         fails     = 0;
    int         n_tests   = 0;
    int         nstart    = 0;
    int         bcnt      = 0;

    always #5 clock = ~clock;

    always @(posedge clock) begin
        if (temp_start === 1'b1) nstart <= nstart + 1;
        if (nv_busy === 1'b1) bcnt <= bcnt + 1;
    end

    tbt_memory_map #(.NV_COPY_CYCLES(20), .ID_CODE(16'h1E87)) i_dut (
        .clock(clock), .rst(rst), .ce(ce), .frame_start(frame_start),
        .bit_stb(bit_stb), .dq_in(line_lvl), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .temp_start(temp_start), .temp_done(temp_done), .temp_half_in(t_half),
        .temp_signed_in(t_sgn), .nv_busy(nv_busy));

    tbt_master i_mst (.clock(clock), .line_lvl(line_lvl), .frame_start(frame_start),
        .bit_stb(bit_stb), .mst_bit(mst_bit));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic cmd(input logic [7:0] c);
        i_mst.frame();
        i_mst.put(c);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cmd(CMD_WR_SCR);
        i_mst.put(a);
        i_mst.put(d);
        i_mst.put(~d);
    endtask

    task automatic rd(input logic [7:0] c, a, e0, e1, e2);
        logic [7:0] v;
        cmd(c);
        i_mst.put(a);
        i_mst.get(v);
        chk(v, e0);
        i_mst.get(v);
        chk(v, e1);
        i_mst.get(v);
        chk(v, e2);
    endtask

    // a busy window that never closes would hang every later frame
    task automatic wait_nv();
        repeat (2) @(posedge clock);
        for (int i = 0; nv_busy !== 1'b0; i++) begin
            if (i == 200) begin
                $display("[FAIL] %0t nv busy timeout got=%h exp=%h", $time, nv_busy, 1'b0);
                fails++;
                end_sim();
            end
            @(posedge clock);
        end
    endtask

    // write and verify, copy out, spoil scratch, copy back, expect e
    task automatic cp(input logic [7:0] a, cpc, ldc, v, e, input logic bz);
        int b0;
        wr(a, v);
        rd(CMD_RD_SCR, a, v, ~v, BYTE_ONES);
        b0 = bcnt;
        cmd(cpc);
        wait_nv();
        chk(8'(bcnt != b0), 8'(bz));
        wr(a, 8'h00);
        cmd(ldc);
        rd(CMD_RD_SCR, a, e, ~e, BYTE_ONES);
    endtask

    // writes into reserved bytes must vanish
    task automatic rsv_scn();
        wr(8'h3E, 8'h11);
        rd(CMD_RD_SCR, 8'h3E, 8'hFF, 8'hFF, 8'h00);
    endtask

    task automatic lock_scn();
        cmd(CMD_LOCK);
        rd(CMD_RD_REGS, ADDR_STAT_LO, 8'h04, 8'h00, 8'hFF);
        cp(8'h16, CMD_CP_SP1, CMD_LD_SP1, 8'h3C, 8'hA5, 1'b0);
        cmd(CMD_UNLOCK);
        cp(8'h16, CMD_CP_SP1, CMD_LD_SP1, 8'h3C, 8'h3C, 1'b1);
    endtask

    task automatic conv_scn();
        cmd(CMD_CONVERT);
        rd(CMD_RD_REGS, ADDR_STAT_LO, 8'h01, 8'h00, 8'hFF);
        chk(8'(nstart), 8'h01);
        @(posedge clock);
        temp_done <= 1'b1;
        t_half    <= 8'hFB;
        t_sgn     <= 8'hD8;
        @(posedge clock);
        temp_done <= 1'b0;
        rd(CMD_RD_REGS, ADDR_TEMP_HALF, 8'hFB, 8'hD8, 8'h00);
    endtask

    // a completion seen while the block is frozen must not reach the results
    task automatic freeze_scn();
        @(posedge clock);
        ce        <= 1'b0;
        temp_done <= 1'b1;
        t_half    <= 8'h11;
        t_sgn     <= 8'h22;
        @(posedge clock);
        temp_done <= 1'b0;
        ce        <= 1'b1;
        rd(CMD_RD_REGS, ADDR_TEMP_HALF, 8'hFB, 8'hD8, 8'h00);
    endtask

    task automatic cyc_scn();
        cmd(CMD_CYC_INC);
        cmd(CMD_CYC_INC);
        rd(CMD_RD_REGS, ADDR_ID_LO, 8'h87, 8'h1E, 8'h02);
        rd(CMD_RD_REGS, ADDR_CYC_HI, 8'h00, 8'hFF, 8'hFF);
        cmd(CMD_CYC_CLR);
        rd(CMD_RD_REGS, ADDR_CYC_LO, 8'h00, 8'h00, 8'hFF);
    endtask

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rsv_scn();
        cp(8'h16, CMD_CP_SP1, CMD_LD_SP1, 8'hA5, 8'hA5, 1'b1);
        cp(8'h26, CMD_CP_SP2, CMD_LD_SP2, 8'h5A, 8'h5A, 1'b1);
        cp(8'h5E, CMD_CP_SP3, CMD_LD_SP3, 8'hC3, 8'hC3, 1'b0);
        lock_scn();
        conv_scn();
        freeze_scn();
        cyc_scn();
        end_sim();
    end
endmodule // tb
